// ### logic/pinmux_pkg.sv
// Shared constants and carrier types for the port B / port C alternate function mux
package pinmux_pkg;

    localparam int PORT_W      = 8;
    localparam int MASK_W      = 3;
    localparam int SYNC_STAGES = 2;

    // Port B pin positions
    localparam int PB_TMR2_T1C = 7;
    localparam int PB_TMR1_B   = 6;
    localparam int PB_TMR1_A   = 5;
    localparam int PB_TMR0     = 4;
    localparam int PB_MISO     = 3;
    localparam int PB_MOSI     = 2;
    localparam int PB_SCK      = 1;
    localparam int PB_SS       = 0;

    // Mask value seen by port C while the legacy mode is on
    localparam logic [MASK_W-1:0] LEGACY_MASK = 3'h0;

    // Address mask below which pin n of port C belongs to the memory interface
    localparam logic [PORT_W-1:0][MASK_W-1:0] ADDR_RELEASE_THRESH = {
        3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h7
    };

    localparam logic [PORT_W-1:0] ALL_ONES  = 8'hff;
    localparam logic [PORT_W-1:0] ALL_ZEROS = 8'h00;

    typedef struct packed {
        logic pullup_override_en;
        logic pullup_override_val;
        logic dir_override_en;
        logic dir_override_val;
        logic value_override_en;
        logic value_override_val;
        logic input_enable_override_en;
        logic input_enable_override_val;
    } pin_override_t;

    typedef pin_override_t [PORT_W-1:0] port_override_t;

endpackage

// ### logic/pin_cell_resolve.sv
// Resolves one pin's drive, value and pull-up from its port bits and overrides
`timescale 1ns/1ps
`default_nettype none
module pin_cell_resolve (
    input  wire logic                      port_bit,
    input  wire logic                      dir_bit,
    input  wire logic                      global_pullup_off,
    input  wire pinmux_pkg::pin_override_t ovr,
    output logic                           pad_out,
    output logic                           pad_oe,
    output logic                           pullup_on
);

    assign pad_oe = ovr.dir_override_en ? ovr.dir_override_val : dir_bit;

    assign pad_out = ovr.value_override_en ? ovr.value_override_val : port_bit;

    // Without a pull-up override, pull-up only acts on an undriven pin; the override value applies whatever the direction
    assign pullup_on = ovr.pullup_override_en ? ovr.pullup_override_val
                                              : (!dir_bit && port_bit && !global_pullup_off);

endmodule
`default_nettype wire

// ### logic/ext_addr_release.sv
// Decides which port C pins the external memory interface owns
`timescale 1ns/1ps
`default_nettype none
module ext_addr_release #(
    parameter int PORT_W = pinmux_pkg::PORT_W,
    parameter int MASK_W = pinmux_pkg::MASK_W
) (
    input  wire logic              ext_mem_on,
    input  wire logic              legacy_mode,
    input  wire logic [MASK_W-1:0] ext_addr_mask,
    output logic      [PORT_W-1:0] owned
);

    logic [MASK_W-1:0] eff_mask;

    assign eff_mask = legacy_mode ? pinmux_pkg::LEGACY_MASK : ext_addr_mask;

    for (genvar i = 0; i < PORT_W; i++) begin : g_pin
        assign owned[i] = ext_mem_on && (eff_mask < pinmux_pkg::ADDR_RELEASE_THRESH[i]);
    end

endmodule
`default_nettype wire

// ### logic/portbc_alt_mux.sv
// Port B timer/SPI and port C high address alternate function mux
`timescale 1ns/1ps
`default_nettype none
module portbc_alt_mux #(
    parameter int PORT_W = pinmux_pkg::PORT_W,
    parameter int MASK_W = pinmux_pkg::MASK_W
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       legacy_mode,
    input  wire logic                       global_pullup_off,
    input  wire logic [PORT_W-1:0]          portb_out_reg,
    input  wire logic [PORT_W-1:0]          portb_dir_reg,
    input  wire logic [PORT_W-1:0]          portb_pad_in,
    input  wire logic [PORT_W-1:0]          portc_out_reg,
    input  wire logic [PORT_W-1:0]          portc_dir_reg,
    input  wire logic                       tmr2_cmp_en,
    input  wire logic                       tmr2_cmp_out,
    input  wire logic                       tmr1_cmp_c_en,
    input  wire logic                       tmr1_cmp_c_out,
    input  wire logic                       tmr1_cmp_b_en,
    input  wire logic                       tmr1_cmp_b_out,
    input  wire logic                       tmr1_cmp_a_en,
    input  wire logic                       tmr1_cmp_a_out,
    input  wire logic                       tmr0_cmp_en,
    input  wire logic                       tmr0_cmp_out,
    input  wire logic                       spi_on,
    input  wire logic                       spi_master_sel,
    input  wire logic                       spi_master_out,
    input  wire logic                       spi_slave_out,
    input  wire logic                       spi_sck_out,
    input  wire logic                       ext_mem_on,
    input  wire logic [MASK_W-1:0]          ext_addr_mask,
    input  wire logic [PORT_W-1:0]          ext_addr_hi,
    output pinmux_pkg::port_override_t      portb_ovr,
    output pinmux_pkg::port_override_t      portc_ovr,
    output logic      [PORT_W-1:0]          portb_pad_out,
    output logic      [PORT_W-1:0]          portb_pad_oe,
    output logic      [PORT_W-1:0]          portb_pullup_on,
    output logic      [PORT_W-1:0]          portc_pad_out,
    output logic      [PORT_W-1:0]          portc_pad_oe,
    output logic      [PORT_W-1:0]          portc_pullup_on,
    output logic                            spi_master_in,
    output logic                            spi_slave_in,
    output logic                            spi_sck_in,
    output logic                            spi_ss_in,
    output logic                            spi_slave_active
);

    localparam int B7 = pinmux_pkg::PB_TMR2_T1C;
    localparam int B6 = pinmux_pkg::PB_TMR1_B;
    localparam int B5 = pinmux_pkg::PB_TMR1_A;
    localparam int B4 = pinmux_pkg::PB_TMR0;
    localparam int B3 = pinmux_pkg::PB_MISO;
    localparam int B2 = pinmux_pkg::PB_MOSI;
    localparam int B1 = pinmux_pkg::PB_SCK;
    localparam int B0 = pinmux_pkg::PB_SS;

    logic                           spi_master;
    logic                           spi_slave;
    logic                           t1c_on;
    logic                           b7_val;
    logic [PORT_W-1:0]              portc_owned;
    logic [B3:B0]                   sync_meta;
    logic [B3:B0]                   sync_q;
    pinmux_pkg::pin_override_t      idle_ovr;

    assign spi_master = spi_on && spi_master_sel;
    assign spi_slave  = spi_on && !spi_master_sel;
    assign idle_ovr   = '0;

    assign t1c_on = tmr1_cmp_c_en && !legacy_mode;

    // Both sources on B7 are merged by the port bit: low ANDs, high ORs
    always_comb begin
        if (tmr2_cmp_en && t1c_on) begin
            b7_val = portb_out_reg[B7] ? (tmr2_cmp_out || tmr1_cmp_c_out)
                                       : (tmr2_cmp_out && tmr1_cmp_c_out);
        end else if (tmr2_cmp_en) begin
            b7_val = tmr2_cmp_out;
        end else begin
            b7_val = tmr1_cmp_c_out;
        end
    end

    always_comb begin
        portb_ovr = {PORT_W{idle_ovr}};
        portb_ovr[B7].value_override_en  = tmr2_cmp_en || t1c_on;
        portb_ovr[B7].value_override_val = b7_val;
        portb_ovr[B6].value_override_en  = tmr1_cmp_b_en;
        portb_ovr[B6].value_override_val = tmr1_cmp_b_out;
        portb_ovr[B5].value_override_en  = tmr1_cmp_a_en;
        portb_ovr[B5].value_override_val = tmr1_cmp_a_out;
        portb_ovr[B4].value_override_en  = tmr0_cmp_en;
        portb_ovr[B4].value_override_val = tmr0_cmp_out;
        portb_ovr[B3].dir_override_en     = spi_master;
        portb_ovr[B3].pullup_override_en  = spi_master;
        portb_ovr[B3].value_override_en  = spi_slave;
        portb_ovr[B3].value_override_val = spi_slave_out;
        portb_ovr[B2].dir_override_en    = spi_slave;
        portb_ovr[B2].pullup_override_en = spi_slave;
        portb_ovr[B2].value_override_en  = spi_master;
        portb_ovr[B2].value_override_val = spi_master_out;
        portb_ovr[B1].dir_override_en    = spi_slave;
        portb_ovr[B1].pullup_override_en = spi_slave;
        portb_ovr[B1].value_override_en  = spi_master;
        portb_ovr[B1].value_override_val = spi_sck_out;
        // SS forced input as slave, value never overridden
        portb_ovr[B0].dir_override_en    = spi_slave;
        portb_ovr[B0].pullup_override_en = spi_slave;
        for (int i = B0; i <= B3; i++) begin
            portb_ovr[i].pullup_override_val = portb_out_reg[i] && !global_pullup_off;
        end
    end

    ext_addr_release #(
        .PORT_W (PORT_W),
        .MASK_W (MASK_W)
    ) u_release (
        .ext_mem_on    (ext_mem_on),
        .legacy_mode   (legacy_mode),
        .ext_addr_mask (ext_addr_mask),
        .owned         (portc_owned)
    );

    // address high byte on port C
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            portc_ovr[i] = idle_ovr;
            // owned pin output, address, no pull-up
            portc_ovr[i].pullup_override_en = portc_owned[i] || legacy_mode;
            portc_ovr[i].dir_override_en    = portc_owned[i] || legacy_mode;
            portc_ovr[i].dir_override_val   = 1'b1;
            portc_ovr[i].value_override_en  = portc_owned[i];
            portc_ovr[i].value_override_val = ext_addr_hi[i];
        end
    end

    // One resolver per pin; port C in legacy mode is held output by its overrides
    for (genvar i = 0; i < PORT_W; i++) begin : g_cell
        pin_cell_resolve u_b (
            .port_bit          (portb_out_reg[i]),
            .dir_bit           (portb_dir_reg[i]),
            .global_pullup_off (global_pullup_off),
            .ovr               (portb_ovr[i]),
            .pad_out           (portb_pad_out[i]),
            .pad_oe            (portb_pad_oe[i]),
            .pullup_on         (portb_pullup_on[i])
        );
        pin_cell_resolve u_c (
            .port_bit          (portc_out_reg[i]),
            .dir_bit           (portc_dir_reg[i]),
            .global_pullup_off (global_pullup_off),
            .ovr               (portc_ovr[i]),
            .pad_out           (portc_pad_out[i]),
            .pad_oe            (portc_pad_oe[i]),
            .pullup_on         (portc_pullup_on[i])
        );
    end

    // SPI pin inputs cross in from the pads, so two flops before use
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_meta <= '0;
            sync_q    <= '0;
        end else begin
            sync_meta <= portb_pad_in[B3:B0];
            sync_q    <= sync_meta;
        end
    end

    assign spi_master_in = sync_q[B3];
    assign spi_slave_in  = sync_q[B2];
    assign spi_sck_in    = sync_q[B1];
    assign spi_ss_in     = sync_q[B0];

    assign spi_slave_active = spi_slave && !sync_q[B0];

    // Checks

    pb7_tmr2_a: assert property (@(posedge clk) disable iff (rst)
        (tmr2_cmp_en && !t1c_on) |->
        portb_ovr[B7].value_override_en && portb_ovr[B7].value_override_val == tmr2_cmp_out)
        else $error("B7 does not carry timer-2 compare");

    pb7_t1c_a: assert property (@(posedge clk) disable iff (rst)
        (!tmr2_cmp_en && tmr1_cmp_c_en && !legacy_mode) |->
        portb_ovr[B7].value_override_en && portb_pad_out[B7] == tmr1_cmp_c_out)
        else $error("B7 does not carry timer-1 compare-C");

    pb7_legacy_a: assert property (@(posedge clk) disable iff (rst)
        (legacy_mode && !tmr2_cmp_en) |-> !portb_ovr[B7].value_override_en)
        else $error("Compare-C reached B7 in legacy mode");

    pb6_cmp_a: assert property (@(posedge clk) disable iff (rst)
        tmr1_cmp_b_en |-> portb_pad_out[B6] == tmr1_cmp_b_out)
        else $error("B6 does not follow compare-B");

    pb5_cmp_a: assert property (@(posedge clk) disable iff (rst)
        tmr1_cmp_a_en |-> portb_pad_out[B5] == tmr1_cmp_a_out)
        else $error("B5 does not follow compare-A");

    pb4_pwm_a: assert property (@(posedge clk) disable iff (rst)
        (tmr0_cmp_en && $past(tmr0_cmp_en) && $changed(tmr0_cmp_out)) |->
        $changed(portb_pad_out[B4]))
        else $error("B4 missed a PWM edge");

    pb4_dir_a: assert property (@(posedge clk) disable iff (rst)
        tmr0_cmp_en |-> portb_pad_oe[B4] == portb_dir_reg[B4]
                        && portb_pad_out[B4] == tmr0_cmp_out)
        else $error("B4 compare drive wrong");

    miso_master_a: assert property (@(posedge clk) disable iff (rst)
        spi_master |-> !portb_pad_oe[B3])
        else $error("MISO driven while master");

    miso_slave_a: assert property (@(posedge clk) disable iff (rst)
        (spi_slave && portb_dir_reg[B3]) |->
        portb_pad_oe[B3] && portb_pad_out[B3] == spi_slave_out)
        else $error("MISO slave drive wrong");

    spi_slave_in_a: assert property (@(posedge clk) disable iff (rst)
        spi_slave |-> portb_pad_oe[B2:B0] == 3'h0)
        else $error("Slave SPI pin driven");

    sck_master_a: assert property (@(posedge clk) disable iff (rst)
        spi_master |-> portb_pad_oe[B1] == portb_dir_reg[B1]
                       && portb_pad_out[B1] == spi_sck_out)
        else $error("SCK master drive wrong");

    ss_value_a: assert property (@(posedge clk) disable iff (rst)
        1'b1 |-> portb_pad_out[B0] == portb_out_reg[B0])
        else $error("SS output value overridden");

    spi_pullup_a: assert property (@(posedge clk) disable iff (rst)
        spi_slave |-> portb_pullup_on[B1] == (portb_out_reg[B1] && !global_pullup_off))
        else $error("SCK pull-up wrong while forced input");

    ss_active_a: assert property (@(posedge clk) disable iff (rst)
        (spi_slave && !$past(rst, 2) && !$past(rst)) |->
        spi_slave_active == !$past(portb_pad_in[B0], 2))
        else $error("Slave activity does not follow SS two cycles late");

    mosi_master_a: assert property (@(posedge clk) disable iff (rst)
        (spi_master && portb_dir_reg[B2]) |-> portb_pad_out[B2] == spi_master_out)
        else $error("MOSI master drive wrong");

    portc_all_a: assert property (@(posedge clk) disable iff (rst)
        (ext_mem_on && ext_addr_mask == 3'h0) |->
        portc_pad_oe == pinmux_pkg::ALL_ONES && portc_pad_out == ext_addr_hi
        && portc_pullup_on == pinmux_pkg::ALL_ZEROS)
        else $error("Port C not fully owned at mask zero");

    portc_mask6_a: assert property (@(posedge clk) disable iff (rst)
        (ext_mem_on && !legacy_mode && ext_addr_mask == 3'h6) |->
        portc_pad_out[1:0] == ext_addr_hi[1:0] && portc_pad_out[7:2] == portc_out_reg[7:2])
        else $error("Port C release at mask six wrong");

    portc_legacy_a: assert property (@(posedge clk) disable iff (rst)
        (legacy_mode && ext_mem_on) |-> portc_pad_out == ext_addr_hi)
        else $error("Legacy mode released address pins");

    portc_out_a: assert property (@(posedge clk) disable iff (rst)
        legacy_mode |-> portc_pad_oe == pinmux_pkg::ALL_ONES)
        else $error("Port C not output only in legacy mode");

    value_ovr_a: assert property (@(posedge clk) disable iff (rst)
        (portb_ovr[B5].value_override_en && portb_pad_oe[B5]) |->
        portb_pad_out[B5] == portb_ovr[B5].value_override_val)
        else $error("Value override ignored");

    dir_ovr_a: assert property (@(posedge clk) disable iff (rst)
        portc_ovr[0].dir_override_en |-> portc_pad_oe[0] == portc_ovr[0].dir_override_val)
        else $error("Direction override ignored");

    same_cycle_a: assert property (@(posedge clk) disable iff (rst)
        $rose(spi_master) |-> !portb_pad_oe[B3])
        else $error("Mode change not seen in the same cycle");

endmodule
`default_nettype wire

// ### dv/periph_model.sv
// Behavioural timers, SPI unit, memory interface and external SPI master
`timescale 1ns/1ps
`default_nettype none
module periph_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ss_low,
    output logic      [4:0] cmp_out,
    output logic      [2:0] spi_out,
    output logic      [7:0] addr_hi,
    output logic      [3:0] pad_lo
);
    logic [7:0] cnt;

    // Free-running count stands in for every waveform except the SS pad, which follows ss_low, so each pin sees both levels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    assign cmp_out = cnt[4:0];
    assign spi_out = {cnt[1], cnt[2], cnt[3]};
    assign addr_hi = cnt ^ 8'h5a;
    assign pad_lo  = {cnt[2], cnt[4], cnt[3], ~ss_low};
endmodule
`default_nettype wire

// ### dv/tb_port_b_c_alternate_function_mux.sv
// Self-checking bench for the port B / port C alternate function mux
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin n_fail++; \
    $display("Error %s expected %h seen %h", nm, ex, gt); end end
module tb_port_b_c_alternate_function_mux;
    logic                       clk, rst, legacy_mode, global_pullup_off, ss_low;
    logic                       spi_on, spi_master_sel, ext_mem_on;
    logic [7:0]                 portb_out_reg, portb_dir_reg, portc_out_reg, portc_dir_reg;
    logic [3:0]                 pad_hi, pad_lo, pd1, pd2;
    logic [4:0]                 cmp_en, cmp_out;
    logic [2:0]                 spi_out, ext_addr_mask;
    logic [7:0]                 ext_addr_hi, bpo, boe, bpu, cpo, coe, cpu, own;
    logic                       mi, si, ki, ssi, act;
    pinmux_pkg::port_override_t bovr, covr;
    int                         n_fail, tests_run;

    always #20 clk = ~clk;

    periph_model pm (.clk(clk), .rst(rst), .ss_low(ss_low), .cmp_out(cmp_out),
        .spi_out(spi_out), .addr_hi(ext_addr_hi), .pad_lo(pad_lo));

    portbc_alt_mux uut (.clk(clk), .rst(rst), .legacy_mode(legacy_mode),
        .global_pullup_off(global_pullup_off), .portb_out_reg(portb_out_reg),
        .portb_dir_reg(portb_dir_reg), .portb_pad_in({pad_hi, pad_lo}),
        .portc_out_reg(portc_out_reg), .portc_dir_reg(portc_dir_reg),
        .tmr2_cmp_en(cmp_en[4]), .tmr2_cmp_out(cmp_out[4]), .tmr1_cmp_c_en(cmp_en[3]),
        .tmr1_cmp_c_out(cmp_out[3]), .tmr1_cmp_b_en(cmp_en[2]), .tmr1_cmp_b_out(cmp_out[2]),
        .tmr1_cmp_a_en(cmp_en[1]), .tmr1_cmp_a_out(cmp_out[1]), .tmr0_cmp_en(cmp_en[0]),
        .tmr0_cmp_out(cmp_out[0]), .spi_on(spi_on), .spi_master_sel(spi_master_sel),
        .spi_master_out(spi_out[2]), .spi_slave_out(spi_out[1]), .spi_sck_out(spi_out[0]),
        .ext_mem_on(ext_mem_on), .ext_addr_mask(ext_addr_mask), .ext_addr_hi(ext_addr_hi),
        .portb_ovr(bovr), .portc_ovr(covr), .portb_pad_out(bpo), .portb_pad_oe(boe),
        .portb_pullup_on(bpu), .portc_pad_out(cpo), .portc_pad_oe(coe),
        .portc_pullup_on(cpu), .spi_master_in(mi), .spi_slave_in(si), .spi_sck_in(ki),
        .spi_ss_in(ssi), .spi_slave_active(act));

    // Reference two-stage copy of the SPI pads
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pd1 <= 4'h0;
            pd2 <= 4'h0;
        end else begin
            pd1 <= pad_lo;
            pd2 <= pd1;
        end
    end

    task automatic end_sim();
        $display("Checks run %0d, errors %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic t_timers();
        int pin;
        portb_dir_reg = 8'hff;
        for (int k = 0; k < 5; k++) begin
            pin = (k == 4) ? 7 : k + 4;
            @(negedge clk);
            portb_out_reg = 8'h00;
            cmp_en = 5'h01 << k;
            for (int c = 0; c < 4; c++) begin
                @(negedge clk);
                #1;
                `CHK("cmp pin", cmp_out[k], bpo[pin])
                `CHK("cmp ovr en", 1'b1, bovr[pin].value_override_en)
            end
            portb_dir_reg = 8'h00;
            #1;
            `CHK("cmp needs dir", 1'b0, boe[pin])
            portb_dir_reg = 8'hff;
            cmp_en = 5'h00;
            portb_out_reg = 8'hff;
            #1;
            `CHK("cmp off", 1'b1, bpo[pin])
        end
        @(negedge clk);
        portb_out_reg = 8'h00;
        cmp_en = 5'h18;
        #1;
        `CHK("b7 and", cmp_out[4] & cmp_out[3], bpo[7])
        portb_out_reg = 8'h80;
        #1;
        `CHK("b7 or", cmp_out[4] | cmp_out[3], bpo[7])
        @(negedge clk);
        legacy_mode = 1'b1;
        portb_out_reg = 8'h00;
        cmp_en = 5'h08;
        #1;
        `CHK("legacy c ovr", 1'b0, bovr[7].value_override_en)
        `CHK("legacy c pin", 1'b0, bpo[7])
        @(negedge clk);
        `CHK("legacy c held", 1'b0, bovr[7].value_override_en)
        cmp_en = 5'h00;
        legacy_mode = 1'b0;
    endtask

    task automatic t_spi_dir();
        logic [3:0] eoe;
        logic       m;
        logic       g;
        spi_on = 1'b1;
        portb_out_reg = 8'h0f;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            m = i[0];
            g = i[1];
            spi_master_sel = m;
            global_pullup_off = g;
            portb_dir_reg = i[2] ? 8'h0f : 8'h00;
            eoe = m ? {1'b0, portb_dir_reg[2:0]} : {portb_dir_reg[3], 3'b000};
            #1;
            `CHK("spi oe", eoe, boe[3:0])
            `CHK("spi pullup", ~eoe & {4{~g}}, bpu[3:0])
            if (m && i[2]) begin
                `CHK("mosi out", spi_out[2], bpo[2])
                `CHK("sck out", spi_out[0], bpo[1])
                `CHK("ss value", 1'b1, bpo[0])
                `CHK("master idle", 1'b0, act)
            end else if (!m && i[2]) begin
                `CHK("miso out", spi_out[1], bpo[3])
            end
        end
        global_pullup_off = 1'b0;
    endtask

    task automatic t_spi_sync();
        @(negedge clk);
        spi_master_sel = 1'b0;
        ss_low = 1'b0;
        repeat (3) @(negedge clk);
        `CHK("ss high idle", 1'b0, act)
        ss_low = 1'b1;
        @(posedge clk);
        #1;
        `CHK("ss one edge", 1'b1, ssi)
        @(posedge clk);
        #1;
        `CHK("ss two edges", 1'b0, ssi)
        `CHK("slave active", 1'b1, act)
        repeat (6) begin
            @(negedge clk);
            `CHK("spi inputs", pd2, {mi, si, ki, ssi})
        end
        ss_low = 1'b0;
        spi_on = 1'b0;
    endtask

    task automatic t_portc();
        ext_mem_on = 1'b1;
        portc_dir_reg = 8'h00;
        portc_out_reg = 8'hff;
        for (int k = 0; k < 8; k++) begin
            @(negedge clk);
            ext_addr_mask = k[2:0];
            for (int i = 0; i < 8; i++) begin
                own[i] = k < ((i >= 2) ? 8 - i : 7);
            end
            #1;
            `CHK("addr oe", own, coe)
            `CHK("addr pullup", ~own, cpu)
            `CHK("addr bits", (ext_addr_hi & own) | (portc_out_reg & ~own), cpo)
            `CHK("addr ovr", own[7], covr[7].value_override_en)
        end
        legacy_mode = 1'b1;
        #1;
        `CHK("legacy mask", 8'hff, coe)
        `CHK("legacy addr", ext_addr_hi, cpo)
        @(negedge clk);
        ext_mem_on = 1'b0;
        portc_out_reg = 8'h3c;
        #1;
        `CHK("legacy out only", 8'hff, coe)
        `CHK("legacy value", 8'h3c, cpo)
        legacy_mode = 1'b0;
        portc_dir_reg = 8'h96;
        #1;
        `CHK("plain port c", 8'h96, coe)
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        {legacy_mode, global_pullup_off, ss_low, spi_on, spi_master_sel, ext_mem_on} = 6'h00;
        {portb_out_reg, portb_dir_reg, portc_out_reg, portc_dir_reg} = 32'h0000_0000;
        pad_hi = 4'h0;
        cmp_en = 5'h00;
        ext_addr_mask = 3'h0;
        n_fail = 0;
        tests_run = 0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_timers();
        t_spi_dir();
        t_spi_sync();
        t_portc();
        end_sim();
    end

    // Whole sequence needs under a hundred cycles; allow far more before giving up
    initial begin
        #400000;
        n_fail++;
        end_sim();
    end
endmodule
`default_nettype wire
